// ===== common/i2ctx_pkg.sv
/*
 * i2ctx_pkg: constants and types for the two-wire transmit buffer block.
 * assumes a 200 MHz system clock; bus pins are sampled, never clocked on.
 */
package i2ctx_pkg;
    localparam int unsigned SYS_CLK_MHZ = 200;
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam logic TX_REQ_RESET = 1'b0;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [3:0] BITCNT_RESET = 4'h0;
    localparam logic [2:0] BC_FULL_BYTE = 3'h0;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] ACK_SLOT = 4'h9;
    localparam int unsigned SYNC_STAGES = 2;
    localparam logic TRS_TRANSMIT = 1'b1;
    localparam logic BIT_ORDER_MSB = 1'b0;
    localparam logic FMT_ADDRESSED = 1'b0;
    typedef enum logic [1:0] {
        I2CTX_IDLE,
        I2CTX_FIRST,
        I2CTX_FRAME
    } i2ctx_state_e;
endpackage

// ===== common/i2ctx_pins_if.sv
/*
 * i2ctx_pins_if: synchronised bus line levels and detected bus events,
 * carried from the pin sampler to the main block on the same clock.
 */
`timescale 1ns/1ps
interface i2ctx_pins_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    modport sampler (output scl, sda, scl_rise, scl_fall, start_det,
        stop_det);
    modport core (input scl, sda, scl_rise, scl_fall, start_det, stop_det);
endinterface

// ===== src/i2ctx_pin_sync.sv
/*
 * i2ctx_pin_sync: two-flop synchronisers on the bus lines plus edge,
 * start and stop detection. assumes lines are open-drain with pull-ups.
 */
`timescale 1ns/1ps
module i2ctx_pin_sync (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // raw bus lines
    input wire logic i_scl,
    input wire logic i_sda,
    // detected events
    i2ctx_pins_if.sampler pins
);
    import i2ctx_pkg::*;
    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic scl_q;
    logic sda_q;
    wire scl_now = scl_sync_q[1];
    wire sda_now = sda_sync_q[1];

    // idle lines are high; resetting to 1 avoids a false start
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[0], i_scl};
            sda_sync_q <= {sda_sync_q[0], i_sda};
            scl_q <= scl_now;
            sda_q <= sda_now;
        end
    end

    assign pins.scl = scl_now;
    assign pins.sda = sda_now;
    assign pins.scl_rise = scl_now & ~scl_q;
    assign pins.scl_fall = ~scl_now & scl_q;
    assign pins.start_det = scl_now & scl_q & sda_q & ~sda_now;
    assign pins.stop_det = scl_now & scl_q & ~sda_q & sda_now;
endmodule

// ===== src/i2ctx_core.sv
/*
 * i2ctx_core: transmit side of a two-wire interface: holding register,
 * shift register, internal write-request flag, frame bit counting.
 * assumes bus pins are asynchronous; software strobes are one-cycle
 * pulses on i_sys_clk. the pins drive sda low only (open drain).
 */
// How it works
// - internal write-request flag, no software access, resets to 0.
// - start condition on the lines sets the flag, either format.
// - frame done with flag 0: load shift register, set flag at the frame's last rise (ninth in a full addressed frame).
// - write after frame done with flag 1: clear, load, set again.
// - software write to the data buffer clears the flag; the code ignores the write, leaving the flag, while receive is selected.
// - stop condition clears the flag in either format.
// - writing interface enable as 0 clears the flag.
// - ack checking on and ack bit 1: flag not set at frame end.
// - addressed format: first frame after start is always nine bits.
// - addressed format: every frame carries an acknowledge bit.
// - serial format: frames carry no acknowledge bit.
// - start is sda falling while scl stays high.
// - stop is sda rising while scl stays high.
// - direction bit 1 means slave to master, 0 master to slave.
// - receiver acknowledges by pulling sda low.
// - data bit count comes from the three-bit count field.
// - bit-order control picks msb first or lsb first.
// - transmit/receive select 1 is transmit, 0 is receive.
`timescale 1ns/1ps
module i2ctx_core (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // bus pins, open drain
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oen,
    // software write port
    input wire logic i_buf_wr,
    input wire logic [7:0] i_buf_wdata,
    input wire logic i_enable_wr,
    input wire logic i_enable_wdata,
    // control and mode bits
    input wire logic i_tx_rx_select,
    input wire logic i_ack_check_enable,
    input wire logic i_serial_format,
    input wire logic [2:0] i_bit_count_field,
    input wire logic i_bit_order_select,
    // status
    output logic o_interface_enable,
    output logic o_frame_done,
    output logic o_ack_bit,
    output logic o_direction_read,
    output logic o_busy,
    output logic o_tx_write_request_flag
);
    import i2ctx_pkg::*;

    i2ctx_pins_if pins ();

    i2ctx_pin_sync u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .pins(pins)
    );

    i2ctx_state_e state_q;
    i2ctx_state_e state_d;
    logic tx_write_request_flag_q;
    logic [7:0] tx_holding_reg_q;
    logic [7:0] shift_reg_q;
    logic [3:0] bit_cnt_q;
    logic [3:0] frame_len_q;
    logic has_ack_q;
    logic ack_bit_q;
    logic dir_read_q;
    logic frame_end_q;
    logic done_pend_q;
    logic interface_enable_q;
    logic sda_out_q;
    logic sda_oen_q;
    logic shift_valid_q;
    logic busy_q;

    // data width from the count field; code 0 means a full byte
    wire [3:0] data_bits = (i_bit_count_field == BC_FULL_BYTE) ?
        BITS_PER_BYTE : {1'b0, i_bit_count_field};
    wire in_frame = (state_q != I2CTX_IDLE);
    wire first_frame = (state_q == I2CTX_FIRST);
    // the counter holds rises already seen, so the last rise finds len-1
    wire [3:0] last_idx = frame_len_q - 4'h1;
    wire ack_slot = has_ack_q && (bit_cnt_q == last_idx);
    wire last_rise = pins.scl_rise && (bit_cnt_q == last_idx)
        && in_frame;
    wire [3:0] next_len = i_serial_format ? data_bits
        : ((pins.start_det || !in_frame) ? ACK_SLOT
        : data_bits + 4'h1);
    wire transmitting = (i_tx_rx_select == TRS_TRANSMIT);
    wire nack_block = (i_serial_format == FMT_ADDRESSED) && has_ack_q
        && i_ack_check_enable && pins.sda;
    wire tx_bit = (i_bit_order_select == BIT_ORDER_MSB) ? shift_reg_q[7]
        : shift_reg_q[0];
    wire clr_enable = i_enable_wr && !i_enable_wdata;
    wire sw_write = i_buf_wr && transmitting;
    // late write: previous frame done while flag still 1
    wire late_write = sw_write && done_pend_q;
    // first byte after a start goes straight out, before any bit clocks
    wire first_load = sw_write && first_frame
        && (bit_cnt_q == BITCNT_RESET);
    wire frame_set = last_rise && !tx_write_request_flag_q
        && !nack_block;
    wire any_set = pins.start_det || frame_set || late_write;
    wire any_clr = pins.stop_det || clr_enable || sw_write;

    always_comb begin
        state_d = state_q;
        if (pins.stop_det || clr_enable) begin
            state_d = I2CTX_IDLE;
        end else if (pins.start_det) begin
            state_d = I2CTX_FIRST;
        end else if (last_rise) begin
            state_d = I2CTX_FRAME;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q <= I2CTX_IDLE;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            busy_q <= (state_d != I2CTX_IDLE);
        end
    end

    // set wins over a buffer-write clear, stop and disable win over set: the refill after a late write must stay visible
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tx_write_request_flag_q <= TX_REQ_RESET;
        end else if (clr_enable || pins.stop_det) begin
            tx_write_request_flag_q <= 1'b0;
        end else if (any_set) begin
            tx_write_request_flag_q <= 1'b1;
        end else if (any_clr) begin
            tx_write_request_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            interface_enable_q <= 1'b0;
        end else if (i_enable_wr) begin
            interface_enable_q <= i_enable_wdata;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tx_holding_reg_q <= BYTE_RESET;
        end else if (sw_write) begin
            tx_holding_reg_q <= i_buf_wdata;
        end
    end

    // done_pend marks a finished frame whose refill waits for software
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            done_pend_q <= 1'b0;
        end else if (any_clr && !last_rise) begin
            done_pend_q <= 1'b0;
        end else if (last_rise && tx_write_request_flag_q) begin
            done_pend_q <= 1'b1;
        end
    end

    // shift register loads from holding data, or directly on a late write or first load
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            shift_reg_q <= BYTE_RESET;
        end else if (late_write || first_load) begin
            shift_reg_q <= i_buf_wdata;
        end else if (frame_set) begin
            shift_reg_q <= tx_holding_reg_q;
        end else if (pins.start_det) begin
            shift_reg_q <= tx_holding_reg_q;
        end else if (pins.scl_fall && in_frame && !ack_slot
                && bit_cnt_q != 4'h0) begin
            if (i_bit_order_select == BIT_ORDER_MSB) begin
                shift_reg_q <= {shift_reg_q[6:0], 1'b0};
            end else begin
                shift_reg_q <= {1'b0, shift_reg_q[7:1]};
            end
        end
    end

    // drive only loaded data: stale bits would hold sda low and mask a stop
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            shift_valid_q <= 1'b0;
        end else if (pins.stop_det || clr_enable || pins.start_det) begin
            shift_valid_q <= 1'b0;
        end else if (late_write || first_load || frame_set) begin
            shift_valid_q <= 1'b1;
        end else if (last_rise) begin
            shift_valid_q <= 1'b0;
        end
    end

    // bit counter counts scl rises within a frame
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            bit_cnt_q <= BITCNT_RESET;
            frame_len_q <= ACK_SLOT;
            has_ack_q <= 1'b1;
        end else if (pins.start_det || last_rise || !in_frame) begin
            bit_cnt_q <= BITCNT_RESET;
            frame_len_q <= next_len;
            has_ack_q <= !i_serial_format;
        end else if (pins.scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
        end
    end

    // sample acknowledge and, in the first frame, the direction bit
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ack_bit_q <= 1'b0;
            dir_read_q <= 1'b0;
            frame_end_q <= 1'b0;
        end else begin
            frame_end_q <= last_rise;
            if (last_rise && has_ack_q) begin
                ack_bit_q <= pins.sda;
            end
            if (pins.scl_rise && first_frame
                    && bit_cnt_q == ACK_SLOT - 4'h2) begin
                dir_read_q <= pins.sda;
            end
        end
    end

    // drive data low only; release during ack slot or receive
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sda_out_q <= 1'b0;
            sda_oen_q <= 1'b1;
        end else if (!interface_enable_q || !transmitting || !in_frame) begin
            sda_oen_q <= 1'b1;
        end else if (!pins.scl) begin
            // only move sda under a low clock, else a false stop or start
            sda_oen_q <= ack_slot || !shift_valid_q || tx_bit;
        end
    end

    assign o_sda_out = sda_out_q;
    assign o_sda_oen = sda_oen_q;
    assign o_interface_enable = interface_enable_q;
    assign o_frame_done = frame_end_q;
    assign o_ack_bit = ack_bit_q;
    assign o_direction_read = dir_read_q;
    assign o_busy = busy_q;
    assign o_tx_write_request_flag = tx_write_request_flag_q;
endmodule

// ===== verif/i2ctx_core_asserts.sv
/* i2ctx_core_asserts: port timing checks for the transmit core.
   assumes one clock domain and a bound instance per core. */
`timescale 1ns/1ps
module i2ctx_asserts (
    // clock, reset and inputs
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_buf_wr,
    input wire logic i_enable_wr,
    input wire logic i_enable_wdata,
    input wire logic i_tx_rx_select,
    input wire logic i_ack_check_enable,
    input wire logic i_serial_format,
    // outputs watched
    input wire logic o_interface_enable,
    input wire logic o_frame_done,
    input wire logic o_ack_bit,
    input wire logic o_tx_write_request_flag
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    wire f = o_tx_write_request_flag;
    // a refused ack only counts in the addressed format with checking on
    wire nak = i_ack_check_enable && !i_serial_format && o_ack_bit;
    property p_rst; $rose(i_rstn) |-> !f; endproperty
    a_rst: assert property (p_rst) else $error("flag after reset");
    property p_dis; i_enable_wr && !i_enable_wdata |=> !f; endproperty
    a_dis: assert property (p_dis) else $error("flag kept");
    property p_en;
        i_enable_wr |=> o_interface_enable == $past(i_enable_wdata);
    endproperty
    a_en: assert property (p_en) else $error("enable lost");
    property p_done; o_frame_done && !f && !nak |-> ##[0:2] f; endproperty
    a_done: assert property (p_done) else $error("no set at end");
    property p_nack; o_frame_done && !f && nak |=> !f ##1 !f; endproperty
    a_nack: assert property (p_nack) else $error("set on nack");
    property p_rx; !i_tx_rx_select && i_buf_wr && f |=> f; endproperty
    a_rx: assert property (p_rx) else $error("rx write taken");
    // detection passes a two-flop sampler, so allow a few edges
    property p_start;
        $fell(i_sda) && i_scl && $past(i_scl) |-> ##[2:6] f;
    endproperty
    a_start: assert property (p_start) else $error("start missed");
    property p_stop;
        $rose(i_sda) && i_scl && $past(i_scl) |-> ##[2:6] !f;
    endproperty
    a_stop: assert property (p_stop) else $error("stop missed");
endmodule
bind i2ctx_core i2ctx_asserts u_asrt (.*);

// ===== verif/i2ctx_bus_model.sv
/* i2ctx_bus_model: far-side master clock and slave ack on the wires.
   assumes pull-ups; a released line reads high. */
`timescale 1ns/1ps
module i2ctx_bus_model (
    // bus lines
    output logic o_scl,
    output logic o_sda,
    input wire logic i_sda
);
    // scl stands still between frames, 64 ns period within them
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic start();
        o_sda = 1'b1;
        #32 o_scl = 1'b1;
        #32 o_sda = 1'b0;
        #32 o_scl = 1'b0;
    endtask
    task automatic stop();
        o_sda = 1'b0;
        #32 o_scl = 1'b1;
        #32 o_sda = 1'b1;
        #32;
    endtask
    // b = 1 releases the line; s is the level seen at the rise
    task automatic clk_bit(input logic b, output logic s);
        o_sda = b;
        #32 o_scl = 1'b1;
        s = i_sda;
        #32 o_scl = 1'b0;
    endtask
endmodule

// ===== verif/tb_i2c_tx_buffer_and_frame_format.sv
/* tb_i2c_tx_buffer_and_frame_format: self-checking bench for the core.
   assumes the bus model stands in for master clock and slave ack. */
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
    n_fail++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, \
    (a), (e)); end end
module tb_i2c_tx_buffer_and_frame_format;
    logic i_sys_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic wr = 1'b0, en_wr = 1'b0, en_d = 1'b0, tx_rx_select = 1'b1;
    logic ack_en = 1'b1, ser = 1'b0, order = 1'b0;
    logic [2:0] bc = 3'h0;
    logic [7:0] wdata = 8'h00, got;
    logic m_scl, m_sda, sda_out, sda_oen, sda_w, en_q, done, ackb;
    logic dir, busy, flag;
    int n_fail = 0, checks_done = 0;
    // wired-and of the model and the open-drain pin
    assign sda_w = m_sda & (sda_oen | sda_out);
    i2ctx_bus_model u_bus (.o_scl(m_scl), .o_sda(m_sda), .i_sda(sda_w));
    i2ctx_core u_dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
        .i_scl(m_scl), .i_sda(sda_w), .o_sda_out(sda_out),
        .o_sda_oen(sda_oen), .i_buf_wr(wr), .i_buf_wdata(wdata),
        .i_enable_wr(en_wr), .i_enable_wdata(en_d),
        .i_tx_rx_select(tx_rx_select), .i_ack_check_enable(ack_en),
        .i_serial_format(ser), .i_bit_count_field(bc),
        .i_bit_order_select(order), .o_interface_enable(en_q),
        .o_frame_done(done), .o_ack_bit(ackb), .o_direction_read(dir),
        .o_busy(busy), .o_tx_write_request_flag(flag));
    task automatic stop_test();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic settle();
        repeat (8) @(posedge i_sys_clk);
    endtask
    task automatic sw_wr(input logic [7:0] b);
        @(posedge i_sys_clk);
        wr <= 1'b1;
        wdata <= b;
        @(posedge i_sys_clk);
        wr <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
    endtask
    task automatic sw_en(input logic v);
        @(posedge i_sys_clk);
        en_wr <= 1'b1;
        en_d <= v;
        @(posedge i_sys_clk);
        en_wr <= 1'b0;
        settle();
    endtask
    task automatic frame(input int n, input logic slot, input logic a);
        logic s;
        got = 8'h00;
        for (int i = 0; i < n; i++) begin
            u_bus.clk_bit(1'b1, s);
            got = {got[6:0], s};
        end
        if (slot) begin
            u_bus.clk_bit(a, s);
        end
        settle();
    endtask
    initial begin
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end
    initial begin
        #60000;
        n_fail++;
        stop_test();
    end
    initial begin
        repeat (3) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        @(posedge i_sys_clk);
        `CHK(flag, 1'b0)
        `CHK(sda_oen, 1'b1)
        `CHK(sda_out, 1'b0)
        sw_en(1'b1);
        `CHK(en_q, 1'b1)
        u_bus.start();
        settle();
        `CHK(flag, 1'b1)
        `CHK(busy, 1'b1)
        sw_wr(8'ha5);
        `CHK(flag, 1'b0)
        frame(8, 1'b0, 1'b0);
        `CHK(flag, 1'b0)
        `CHK(got, 8'ha5)
        `CHK(dir, 1'b1)
        frame(0, 1'b1, 1'b0);
        `CHK(flag, 1'b1)
        `CHK(ackb, 1'b0)
        // no write in this frame, so it completes with the flag at 1
        frame(8, 1'b1, 1'b0);
        `CHK(got, 8'ha5)
        `CHK(flag, 1'b1)
        // bit order changes only between frames
        order <= 1'b1;
        sw_wr(8'h1e);
        `CHK(flag, 1'b1)
        sw_wr(8'h5a);
        `CHK(flag, 1'b0)
        frame(8, 1'b1, 1'b1);
        `CHK(got, 8'h78)
        `CHK(ackb, 1'b1)
        `CHK(flag, 1'b0)
        u_bus.stop();
        u_bus.start();
        settle();
        `CHK(flag, 1'b1)
        u_bus.stop();
        settle();
        `CHK(flag, 1'b0)
        `CHK(busy, 1'b0)
        order <= 1'b0;
        ser <= 1'b1;
        bc <= 3'h4;
        u_bus.start();
        settle();
        sw_wr(8'hc3);
        frame(3, 1'b0, 1'b0);
        `CHK(flag, 1'b0)
        `CHK(got, 8'h06)
        frame(1, 1'b0, 1'b0);
        `CHK(flag, 1'b1)
        tx_rx_select <= 1'b0;
        sw_wr(8'h00);
        `CHK(flag, 1'b1)
        sw_en(1'b0);
        `CHK(flag, 1'b0)
        u_bus.stop();
        stop_test();
    end
endmodule
